/* power_mode_pkg.sv */
// Shared constants and carrier types for the power-mode controller
package power_mode_pkg;
    localparam logic [7:0] power_control_addr  = 8'h87;
    localparam logic [7:0] power_control_reset = 8'h00;
    localparam int         idle_bit            = 0;
    localparam int         stop_bit            = 1;
    localparam logic [7:0] writable_mask       = 8'h03;
    localparam logic [15:0] reset_vector       = 16'h0000;

    // Missing-clock detector timeout and its count at 40 MHz
    localparam int clk_period_ns    = 25;
    localparam int monitor_timeout_us = 100;
    localparam int monitor_timeout_cycles =
        (monitor_timeout_us * 1000) / clk_period_ns;

    typedef enum logic [1:0] {
        run_state     = 2'b00,
        idle_state    = 2'b01,
        stop_state    = 2'b10,
        suspend_state = 2'b11
    } mode_type;

    // Special function register port from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;

    // Gating outputs toward the rest of the chip
    typedef struct packed {
        logic cpu_halt;
        logic periph_clk_en;
        logic int_osc_en;
        logic timers_en;
        logic irq_en;
    } gate_type;
endpackage

/* reset_source.sv */
// Watchdog and missing-clock reset request generator
module reset_source #(
    parameter int timeout_cycles = power_mode_pkg::monitor_timeout_cycles,
    parameter int wdt_width      = 16
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 watchdog_enable,
    input  wire logic                 watchdog_kick,
    input  wire logic [wdt_width-1:0] watchdog_limit,
    input  wire logic                 monitor_enable,
    input  wire logic                 in_stop,
    output logic                      internal_reset_req
);
    localparam int cw = $clog2(timeout_cycles + 1);
    logic [wdt_width-1:0] wdt_count_q;
    logic [cw-1:0]        mon_count_q;
    logic                 wdt_fire;
    logic                 mon_fire;

    // Watchdog keeps counting through Idle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_count_q <= '0;
        end else if (!watchdog_enable || watchdog_kick) begin
            wdt_count_q <= '0;
        end else if (!wdt_fire) begin
            wdt_count_q <= wdt_count_q + 1'b1;
        end
    end
    assign wdt_fire = watchdog_enable && (wdt_count_q == watchdog_limit);

    // Stop freezes the clock, so the detector sees it missing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon_count_q <= '0;
        end else if (!(monitor_enable && in_stop)) begin
            mon_count_q <= '0;
        end else if (!mon_fire) begin
            mon_count_q <= mon_count_q + 1'b1;
        end
    end
    assign mon_fire = (mon_count_q == cw'(timeout_cycles));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            internal_reset_req <= 1'b0;
        end else begin
            internal_reset_req <= wdt_fire || mon_fire;
        end
    end
endmodule

/* cpu_power_mode_control.sv */
// Idle, Stop and Suspend control with the power control register
// Function
// - Writing one to bit 0 with bit 1 clear enters Idle after the writing instruction ends.
// - Idle halts the CPU; peripherals and internal clocks keep running.
// - Entering Idle leaves registers and memory untouched.
// - Only an enabled interrupt or any reset ends Idle.
// - Enabled interrupt in Idle clears the idle bit and resumes the CPU.
// - After interrupt return, execution continues after the Idle write.
// - Reset out of Idle runs the reset sequence from address zero.
// - Enabled watchdog keeps counting in Idle and resets the device.
// - Writing one to bit 1 enters Stop after the writing instruction.
// - Stop halts internal oscillator, CPU and digital peripherals.
// - In Stop interrupts and timers are inactive except the clock monitor and an enabled watchdog.
// - Only a reset ends Stop, restarting from address zero.
// - Enabled clock monitor resets the device out of Stop.
// - Suspend stops the internal oscillator until a wake-up event.
module cpu_power_mode_control #(
    parameter int timeout_cycles = power_mode_pkg::monitor_timeout_cycles,
    parameter int wdt_width      = 16
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        ext_rst,
    input  power_mode_pkg::sfr_req_type      sfr_req,
    input  wire logic                        instr_done,
    input  wire logic                        enabled_irq,
    input  wire logic                        suspend_req,
    input  wire logic                        wake_event,
    input  wire logic                        watchdog_enable,
    input  wire logic                        watchdog_kick,
    input  wire logic [wdt_width-1:0]        watchdog_limit,
    input  wire logic                        monitor_enable,
    output logic [7:0]                       sfr_rdata,
    output power_mode_pkg::gate_type         gates,
    output power_mode_pkg::mode_type         mode,
    output logic                             core_reset,
    output logic [15:0]                      restart_pc,
    output logic                             irq_resume
);
    logic [7:0]                power_control_q;
    power_mode_pkg::mode_type  mode_q;
    power_mode_pkg::mode_type  mode_d;
    logic                      pend_idle_q;
    logic                      pend_stop_q;
    logic                      ext_rst_meta_q;
    logic                      ext_rst_sync_q;
    logic                      wake_meta_q;
    logic                      wake_sync_q;
    logic                      internal_reset_req;
    logic                      any_reset;
    logic                      pc_write;
    logic                      irq_wake;

    // Every property below runs on clk and is off during reset
    default clocking assert_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Pin inputs cross into the clock domain first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_rst_meta_q <= 1'b0;
            ext_rst_sync_q <= 1'b0;
            wake_meta_q    <= 1'b0;
            wake_sync_q    <= 1'b0;
        end else begin
            ext_rst_meta_q <= ext_rst;
            ext_rst_sync_q <= ext_rst_meta_q;
            wake_meta_q    <= wake_event;
            wake_sync_q    <= wake_meta_q;
        end
    end

    reset_source #(
        .timeout_cycles (timeout_cycles),
        .wdt_width      (wdt_width)
    ) reset_source_inst (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .watchdog_enable    (watchdog_enable),
        .watchdog_kick      (watchdog_kick),
        .watchdog_limit     (watchdog_limit),
        .monitor_enable     (monitor_enable),
        .in_stop            (mode_q == power_mode_pkg::stop_state),
        .internal_reset_req (internal_reset_req)
    );

    assign any_reset = ext_rst_sync_q || internal_reset_req;
    assign pc_write  = sfr_req.wr
                    && (sfr_req.addr == power_mode_pkg::power_control_addr);
    // Interrupts are ignored while Stop holds them inactive
    assign irq_wake  = enabled_irq
                    && (mode_q == power_mode_pkg::idle_state);

    // Register write; hardware clear of idle bit on interrupt wake
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_control_q <= power_mode_pkg::power_control_reset;
        end else if (any_reset) begin
            power_control_q <= power_mode_pkg::power_control_reset;
        end else if (pc_write) begin
            power_control_q <= sfr_req.wdata
                             & power_mode_pkg::writable_mask;
        end else if (irq_wake) begin
            power_control_q[power_mode_pkg::idle_bit] <= 1'b0;
        end
    end

    // Mode entry waits for the writing instruction to complete
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_idle_q <= 1'b0;
            pend_stop_q <= 1'b0;
        end else if (any_reset || instr_done) begin
            pend_idle_q <= 1'b0;
            pend_stop_q <= 1'b0;
        end else if (pc_write) begin
            pend_idle_q <= sfr_req.wdata[power_mode_pkg::idle_bit];
            pend_stop_q <= sfr_req.wdata[power_mode_pkg::stop_bit];
        end
    end

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            power_mode_pkg::run_state: begin
                if (instr_done && pend_stop_q) begin
                    mode_d = power_mode_pkg::stop_state;
                end else if (instr_done && pend_idle_q) begin
                    mode_d = power_mode_pkg::idle_state;
                end else if (suspend_req) begin
                    mode_d = power_mode_pkg::suspend_state;
                end
            end
            power_mode_pkg::idle_state: begin
                if (irq_wake) begin
                    mode_d = power_mode_pkg::run_state;
                end
            end
            power_mode_pkg::stop_state: begin
                mode_d = power_mode_pkg::stop_state;
            end
            power_mode_pkg::suspend_state: begin
                if (wake_sync_q) begin
                    mode_d = power_mode_pkg::run_state;
                end
            end
        endcase
    end

    // Any reset wins over every mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= power_mode_pkg::run_state;
        end else if (any_reset) begin
            mode_q <= power_mode_pkg::run_state;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Reset pulse to the core restarts fetch at the reset vector
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset <= 1'b1;
            restart_pc <= power_mode_pkg::reset_vector;
        end else begin
            core_reset <= any_reset;
            restart_pc <= power_mode_pkg::reset_vector;
        end
    end

    // Resume pulse: the core services the interrupt, and its return
    // address is the instruction after the Idle write, since the PC
    // was frozen and nothing here touches core state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_resume <= 1'b0;
        end else begin
            irq_resume <= irq_wake && !any_reset;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd
                     && sfr_req.addr
                        == power_mode_pkg::power_control_addr) begin
            sfr_rdata <= power_control_q;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Gating: Idle only freezes the CPU clock, so state is held
    always_comb begin
        gates.cpu_halt      = (mode_q != power_mode_pkg::run_state);
        gates.periph_clk_en = (mode_q == power_mode_pkg::run_state)
                           || (mode_q == power_mode_pkg::idle_state);
        gates.int_osc_en    = (mode_q == power_mode_pkg::run_state)
                           || (mode_q == power_mode_pkg::idle_state);
        gates.timers_en     = gates.periph_clk_en;
        gates.irq_en        = gates.periph_clk_en;
    end
    assign mode = mode_q;

    a_idle_entry: assert property (
        (mode_q == power_mode_pkg::run_state && instr_done && pend_idle_q
         && !pend_stop_q && !any_reset)
        |=> mode_q == power_mode_pkg::idle_state)
        else $error("idle not entered after instruction");
    a_stop_entry: assert property (
        (mode_q == power_mode_pkg::run_state && instr_done && pend_stop_q
         && !any_reset) |=> mode_q == power_mode_pkg::stop_state)
        else $error("stop not entered after instruction");
    a_idle_clocks: assert property (
        mode_q == power_mode_pkg::idle_state |->
        gates.cpu_halt && gates.periph_clk_en && gates.int_osc_en)
        else $error("idle gating wrong");
    a_stop_gating: assert property (
        mode_q == power_mode_pkg::stop_state |->
        gates.cpu_halt && !gates.periph_clk_en && !gates.int_osc_en
        && !gates.timers_en && !gates.irq_en)
        else $error("stop gating wrong");
    a_suspend_osc: assert property (
        mode_q == power_mode_pkg::suspend_state |-> !gates.int_osc_en)
        else $error("suspend left oscillator running");
    a_irq_clears_idle: assert property (
        (irq_wake && !pc_write && !any_reset) |=>
        !power_control_q[power_mode_pkg::idle_bit] && irq_resume
        && mode_q == power_mode_pkg::run_state)
        else $error("interrupt did not end idle");
    a_stop_holds: assert property (
        (mode_q == power_mode_pkg::stop_state && !any_reset) |=>
        mode_q == power_mode_pkg::stop_state)
        else $error("stop left without reset");
    a_idle_holds: assert property (
        (mode_q == power_mode_pkg::idle_state && !enabled_irq && !any_reset)
        |=> mode_q == power_mode_pkg::idle_state)
        else $error("idle left without cause");
    a_reset_vector: assert property (
        any_reset |=> core_reset
        && restart_pc == power_mode_pkg::reset_vector
        && mode_q == power_mode_pkg::run_state)
        else $error("reset did not restart core");
    a_both_bits: assert property (
        (pend_idle_q && pend_stop_q && instr_done && !any_reset
         && mode_q == power_mode_pkg::run_state) |=>
        mode_q == power_mode_pkg::stop_state)
        else $error("stop lost precedence");
endmodule

/* cpu_power_mode_control_tb_top.sv */
// Self-checking bench for the power-mode controller
module cpu_power_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int sim_timeout = 20;
    logic                          clk             = 1'b0;
    logic                          sys_rst         = 1'b1;
    logic                          ext_rst         = 1'b0;
    power_mode_pkg::sfr_req_type   sfr_req         = '0;
    logic                          instr_done      = 1'b0;
    logic                          enabled_irq     = 1'b0;
    logic                          suspend_req     = 1'b0;
    logic                          wake_event      = 1'b0;
    logic                          watchdog_enable = 1'b0;
    logic                          watchdog_kick   = 1'b0;
    logic [15:0]                   watchdog_limit  = 16'h0010;
    logic                          monitor_enable  = 1'b0;
    logic [7:0]                    sfr_rdata;
    power_mode_pkg::gate_type      gates;
    power_mode_pkg::mode_type      mode;
    logic                          core_reset;
    logic [15:0]                   restart_pc;
    logic                          irq_resume;
    int                            fail_count      = 0;
    int                            num_checks      = 0;
    logic                          seen_rst;
    logic                          seen_resume;
    logic [7:0]                    d;

    always #12.5 clk = ~clk;

    cpu_power_mode_control #(.timeout_cycles(sim_timeout), .wdt_width(16))
    cpu_power_mode_control_inst (
        .clk(clk), .sys_rst(sys_rst), .ext_rst(ext_rst), .sfr_req(sfr_req),
        .instr_done(instr_done), .enabled_irq(enabled_irq),
        .suspend_req(suspend_req), .wake_event(wake_event),
        .watchdog_enable(watchdog_enable), .watchdog_kick(watchdog_kick),
        .watchdog_limit(watchdog_limit), .monitor_enable(monitor_enable),
        .sfr_rdata(sfr_rdata), .gates(gates), .mode(mode),
        .core_reset(core_reset), .restart_pc(restart_pc),
        .irq_resume(irq_resume)
    );

    function automatic logic [7:0] exp_read(input logic [7:0] v);
        return v & power_mode_pkg::writable_mask;
    endfunction

    // Stop outranks idle when both bits are written together
    function automatic power_mode_pkg::mode_type exp_mode(
        input logic [7:0] v);
        if (v[power_mode_pkg::stop_bit]) return power_mode_pkg::stop_state;
        if (v[power_mode_pkg::idle_bit]) return power_mode_pkg::idle_state;
        return power_mode_pkg::run_state;
    endfunction

    // Order: cpu_halt, periph_clk_en, int_osc_en, timers_en, irq_en
    function automatic logic [4:0] exp_gates(
        input power_mode_pkg::mode_type m);
        if (m == power_mode_pkg::idle_state) return 5'h1f;
        if (m == power_mode_pkg::stop_state) return 5'h10;
        return 5'h0f;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
    endtask

    task automatic sfr_check(input logic [7:0] exp);
        @(posedge clk);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h87, wdata: 8'h00};
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        #1;
        chk("power_control", 16'(exp), 16'(sfr_rdata));
    endtask

    task automatic pulse_done();
        @(posedge clk);
        instr_done <= 1'b1;
        @(posedge clk);
        instr_done <= 1'b0;
    endtask

    // Bounded wait; running out of cycles ends the run
    task automatic wait_mode(input power_mode_pkg::mode_type m,
                             input int bound);
        int n;
        n = 0;
        seen_rst = 1'b0;
        seen_resume = 1'b0;
        do begin
            @(posedge clk);
            #1;
            if (core_reset === 1'b1) seen_rst = 1'b1;
            if (irq_resume === 1'b1) seen_resume = 1'b1;
            n++;
        end while (mode !== m && n < bound);
        chk("mode", 16'(m), 16'(mode));
        if (mode !== m) results();
    endtask

    task automatic reset_exit();
        @(posedge clk);
        ext_rst <= 1'b1;
        wait_mode(power_mode_pkg::run_state, 8);
        chk("core_reset seen", 16'h0001, 16'(seen_rst));
        chk("restart_pc", power_mode_pkg::reset_vector, restart_pc);
        @(posedge clk);
        ext_rst <= 1'b0;
        repeat (6) @(posedge clk);
        sfr_check(8'h00);
    endtask

    initial begin
        void'($urandom(32'haa6b));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // Both monitors stay off so Idle lasts until an interrupt or reset and Stop until an external reset
        watchdog_enable <= 1'b0;
        monitor_enable <= 1'b0;
        repeat (2) @(posedge clk);
        sfr_check(power_mode_pkg::power_control_reset);
        sfr_write(8'h86, 8'hff);
        sfr_check(8'h00);
        // Random entries; a corner pattern with both bits leads the list
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            sfr_write(power_mode_pkg::power_control_addr, d);
            sfr_check(exp_read(d));
            pulse_done();
            wait_mode(exp_mode(d), 2);
            chk("gates", 16'(exp_gates(exp_mode(d))),
                16'(gates));
            if (exp_mode(d) == power_mode_pkg::idle_state) begin
                repeat (6) @(posedge clk);
                #1;
                chk("idle holds", 16'(power_mode_pkg::idle_state),
                    16'(mode));
                @(posedge clk);
                enabled_irq <= 1'b1;
                wait_mode(power_mode_pkg::run_state, 3);
                chk("irq_resume", 16'h0001, 16'(seen_resume));
                @(posedge clk);
                enabled_irq <= 1'b0;
                sfr_check(exp_read(d) & 8'hfe);
            end else if (exp_mode(d) == power_mode_pkg::stop_state) begin
                @(posedge clk);
                enabled_irq <= 1'b1;
                repeat (5) @(posedge clk);
                #1;
                chk("stop holds", 16'(power_mode_pkg::stop_state),
                    16'(mode));
                @(posedge clk);
                enabled_irq <= 1'b0;
                reset_exit();
            end
        end
        // Idle ended by an external reset
        sfr_write(power_mode_pkg::power_control_addr, 8'h01);
        pulse_done();
        wait_mode(power_mode_pkg::idle_state, 2);
        reset_exit();
        // Watchdog keeps counting while idle
        sfr_write(power_mode_pkg::power_control_addr, 8'h01);
        pulse_done();
        wait_mode(power_mode_pkg::idle_state, 2);
        @(posedge clk);
        watchdog_limit <= 16'(10 + $urandom_range(30));
        watchdog_kick <= 1'b1;
        watchdog_enable <= 1'b1;
        @(posedge clk);
        watchdog_kick <= 1'b0;
        wait_mode(power_mode_pkg::run_state, 60);
        chk("watchdog reset", 16'h0001, 16'(seen_rst));
        @(posedge clk);
        watchdog_enable <= 1'b0;
        // Clock monitor armed before stop forces a reset
        monitor_enable <= 1'b1;
        sfr_write(power_mode_pkg::power_control_addr, 8'h02);
        pulse_done();
        wait_mode(power_mode_pkg::stop_state, 2);
        wait_mode(power_mode_pkg::run_state, sim_timeout + 8);
        chk("monitor reset", 16'h0001, 16'(seen_rst));
        @(posedge clk);
        monitor_enable <= 1'b0;
        repeat (4) @(posedge clk);
        // Suspend holds the oscillator off until woken
        suspend_req <= 1'b1;
        @(posedge clk);
        suspend_req <= 1'b0;
        wait_mode(power_mode_pkg::suspend_state, 4);
        repeat (5) @(posedge clk);
        #1;
        chk("suspend osc", 16'h0000, 16'(gates.int_osc_en));
        @(posedge clk);
        wake_event <= 1'b1;
        wait_mode(power_mode_pkg::run_state, 8);
        @(posedge clk);
        wake_event <= 1'b0;
        results();
    end
endmodule
